// [sbs_cfg.svh]
/*
  constants of the synchronous burst sram pin control block: widths, depths,
  field masks and reset values.
  assumes it is included by its bare name wherever these macros are used.
*/
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH

// array geometry
`define SBS_ADDR_W 18
`define SBS_DATA_W 16
`define SBS_PAR_W 2
`define SBS_WORD_W 18
`define SBS_DEPTH 262144

// write buffer
`define SBS_FIFO_DEPTH 16
`define SBS_ENTRY_W 38

// byte lane enables, bit 0 is lane 0
`define SBS_LANE_ALL 2'b11
`define SBS_LANE_NONE 2'b00

// word bits covered by each lane: data byte plus its parity bit
`define SBS_LANE0_MASK 18'h1_00FF
`define SBS_LANE1_MASK 18'h2_FF00

// values assumed for an undriven pad, and counter and register reset values
`define SBS_MODE_FLOAT 1'b1
`define SBS_SLEEP_FLOAT 1'b0
`define SBS_SEQ_RST 2'h0
`define SBS_ADDR_RST 18'h0_0000
`define SBS_DATA_RST 16'h0000
`define SBS_PAR_RST 2'h0

`endif

// [sbs_host_pad.sv]
/*
  far side of the pin bus: the processor's data drivers and the pad wiring
  of the common data and parity lines.
  assumes the device's output enables are low while it drives the lines.
*/
`timescale 1ns/1ps
`default_nettype none

module sbs_host_pad
(
  // clock
  input wire logic ref_clk_i,
  // processor side
  input wire sbs_pkg::sbs_word_t host_word_i,
  input wire logic host_drive_i,
  // device side
  input wire sbs_pkg::sbs_data_t dev_data_i,
  input wire logic dev_data_oe_n_i,
  input wire sbs_pkg::sbs_par_t dev_par_i,
  input wire logic dev_par_oe_n_i,
  // resolved lines
  output sbs_pkg::sbs_data_t line_data_o,
  output sbs_pkg::sbs_par_t line_par_o
);
  import sbs_pkg::*;

  sbs_word_t last = '0;
  sbs_word_t float_word;

  ////////////////////////////////////////////////////////////////////////////////

  // undriven lines show the inverse of their last value, so stale data never reads as good
  always_ff @(posedge ref_clk_i)
  begin
    last <= {line_par_o, line_data_o};
  end

  assign float_word = ~last;

  always_comb
  begin
    line_data_o = host_drive_i ? host_word_i[15:0] : float_word[15:0];
    line_par_o = host_drive_i ? host_word_i[17:16] : float_word[17:16];
    if (!dev_data_oe_n_i)
      line_data_o = dev_data_i;
    if (!dev_par_oe_n_i)
      line_par_o = dev_par_i;
  end
endmodule

`default_nettype wire

// [sbs_pkg.sv]
/*
  types shared by the synchronous burst sram pin control block.
  assumes sbs_cfg.svh is reachable by its bare name.
*/
`default_nettype none
`include "sbs_cfg.svh"

package sbs_pkg;

  typedef logic [`SBS_ADDR_W-1:0] sbs_addr_t;
  typedef logic [`SBS_DATA_W-1:0] sbs_data_t;
  typedef logic [`SBS_PAR_W-1:0] sbs_par_t;
  typedef logic [`SBS_WORD_W-1:0] sbs_word_t;
  typedef logic [1:0] sbs_lanes_t;
  typedef logic [1:0] sbs_seq_t;

  // access sequencer states
  typedef enum logic [2:0]
  {
    SBS_IDLE = 3'b001,
    SBS_BURST = 3'b010,
    SBS_SLEEP = 3'b100
  } sbs_state_t;

endpackage

`default_nettype wire

// [sbs_sram.sv]
/*
  synchronous burst sram pin control: a write buffer and the top module
  that decodes selects, strobes and write controls, runs the two-bit burst
  counter, keeps the array and drives the common data and parity lines.
  assumes a single 100 MHz clock, all inputs synchronous to it, and a pad
  ring that resolves the data and parity lines from the enables.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sbs_cfg.svh"

////////////////////////////////////////////////////////////////////////////////

module sbs_fifo #(
  parameter int W = 38,
  parameter int DEPTH = 16
)
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = DEPTH[AW:0];

  logic [W-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_valid_o = count != '0;
  assign out_data_o = store[rd_ptr];

  always_comb
  begin
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      count <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      in_ready_o <= 1'b1;
    end
    else
    begin
      count <= next_count;
      in_ready_o <= next_count != FULL;
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (push)
    begin
      store[wr_ptr] <= in_data_i;
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////////

module sbs_sram
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // address and strobes
  input wire sbs_pkg::sbs_addr_t addr_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic burst_step_n_i,
  // chip selects
  input wire logic chip_select_one_n_i,
  input wire logic chip_select_two_i,
  input wire logic chip_select_three_n_i,
  // write controls
  input wire logic global_write_n_i,
  input wire logic byte_write_enable_n_i,
  input wire sbs_pkg::sbs_lanes_t byte_lane_select_n_i,
  // output enable, sleep and burst order straps
  input wire logic output_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic sleep_pin_driven_i,
  input wire logic burst_mode_i,
  input wire logic mode_pin_driven_i,
  // data lines
  input wire sbs_pkg::sbs_data_t data_i,
  output sbs_pkg::sbs_data_t data_o,
  output logic data_oe_n_o,
  // parity lines
  input wire sbs_pkg::sbs_par_t parity_lines_i,
  output sbs_pkg::sbs_par_t parity_lines_o,
  output logic parity_oe_n_o,
  // status
  output logic write_ready_o,
  output logic sleeping_o
);
  import sbs_pkg::*;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // two-bit burst address for step k from the first address
  function automatic sbs_seq_t burst_addr(input sbs_seq_t first, input sbs_seq_t k,
                                          input logic interleave);
    burst_addr = interleave ? (first ^ k) : sbs_seq_t'(first + k);
  endfunction

  // lanes written by the current write controls
  function automatic sbs_lanes_t lanes_of(input logic gw_n, input logic bwe_n,
                                          input sbs_lanes_t bws_n);
    if (!gw_n)
    begin
      lanes_of = `SBS_LANE_ALL;
    end
    else if (!bwe_n)
    begin
      lanes_of = ~bws_n;
    end
    else
    begin
      lanes_of = `SBS_LANE_NONE;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  sbs_word_t mem [`SBS_DEPTH];
  sbs_state_t state;
  sbs_addr_t base;
  sbs_seq_t seq;
  sbs_seq_t cur_lo;
  sbs_seq_t step_lo;
  sbs_addr_t acc_addr;
  sbs_word_t rd_word;
  sbs_lanes_t wr_lanes;
  logic sleep_pin;
  logic interleave;
  logic awake;
  logic selected;
  logic start_p;
  logic start_c;
  logic start;
  logic desel;
  logic cont;
  logic wr_req;
  logic wr_detect;
  logic wr_go;
  logic rd_now;
  logic fifo_ready;
  logic drain_valid;
  logic [`SBS_ENTRY_W-1:0] drain_entry;
  sbs_addr_t drain_addr;
  sbs_lanes_t drain_lanes;
  sbs_word_t drain_word;
  sbs_word_t drain_mask;

  // pad pulls stand in for undriven sleep and mode pins
  assign sleep_pin = sleep_pin_driven_i ? sleep_request_i : `SBS_SLEEP_FLOAT;
  assign interleave = mode_pin_driven_i ? burst_mode_i : `SBS_MODE_FLOAT;
  assign awake = (state != SBS_SLEEP) && !sleep_pin;

  assign selected = !chip_select_one_n_i && chip_select_two_i
                    && !chip_select_three_n_i;
  assign start_p = awake && selected && !chip_select_one_n_i
                   && !processor_addr_strobe_n_i;
  assign start_c = awake && selected && processor_addr_strobe_n_i
                   && !controller_addr_strobe_n_i;
  assign start = start_p || start_c;
  assign desel = awake && !selected && (!controller_addr_strobe_n_i
                 || (!processor_addr_strobe_n_i && !chip_select_one_n_i));
  assign cont = awake && (state == SBS_BURST) && !start && !desel;

  assign wr_lanes = lanes_of(global_write_n_i, byte_write_enable_n_i,
                             byte_lane_select_n_i);
  assign wr_req = wr_lanes != `SBS_LANE_NONE;
  // the first cycle of a processor strobe ignores the write controls
  assign wr_detect = wr_req && (start_c || cont);
  assign wr_go = wr_detect && fifo_ready;
  assign rd_now = start_p || ((start_c || cont) && !wr_req);

  //////////////////////////////////////////////////////////////////////////////

  assign cur_lo = burst_addr(base[1:0], seq, interleave);
  assign step_lo = burst_addr(base[1:0], sbs_seq_t'(seq + 1'b1), interleave);

  always_comb
  begin
    acc_addr = {base[`SBS_ADDR_W-1:2], burst_step_n_i ? cur_lo : step_lo};
    if (start)
    begin
      acc_addr = addr_i;
    end
  end

  assign rd_word = mem[acc_addr];

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state <= SBS_IDLE;
    end
    else
    begin
      unique case (state)
        SBS_IDLE:
        begin
          if (sleep_pin)
          begin
            state <= SBS_SLEEP;
          end
          else if (start)
          begin
            state <= SBS_BURST;
          end
        end
        SBS_BURST:
        begin
          if (sleep_pin)
          begin
            state <= SBS_SLEEP;
          end
          else if (desel)
          begin
            state <= SBS_IDLE;
          end
        end
        SBS_SLEEP:
        begin
          if (!sleep_pin)
          begin
            state <= SBS_IDLE;
          end
        end
        default:
        begin
          state <= SBS_IDLE;
        end
      endcase
    end
  end

  // address register and burst counter
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      base <= `SBS_ADDR_RST;
      seq <= `SBS_SEQ_RST;
    end
    else if (start)
    begin
      base <= addr_i;
      seq <= `SBS_SEQ_RST;
    end
    else if (cont && !burst_step_n_i)
    begin
      seq <= seq + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // writes queue here; the array port drains them when no read needs it
  sbs_fifo #(
    .W(`SBS_ENTRY_W),
    .DEPTH(`SBS_FIFO_DEPTH)
  ) u_wbuf (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(wr_go),
    .in_data_i({acc_addr, wr_lanes, parity_lines_i, data_i}),
    .in_ready_o(fifo_ready),
    .out_valid_o(drain_valid),
    .out_data_o(drain_entry),
    .out_ready_i(!rd_now)
  );

  assign drain_addr = drain_entry[`SBS_ENTRY_W-1 -: `SBS_ADDR_W];
  assign drain_lanes = drain_entry[`SBS_WORD_W+1:`SBS_WORD_W];
  assign drain_word = drain_entry[`SBS_WORD_W-1:0];
  assign drain_mask = (drain_lanes[0] ? `SBS_LANE0_MASK : '0)
                      | (drain_lanes[1] ? `SBS_LANE1_MASK : '0);

  // array has no reset: contents survive reset and sleep
  always_ff @(posedge ref_clk_i)
  begin
    if (drain_valid && !rd_now)
    begin
      mem[drain_addr] <= (mem[drain_addr] & ~drain_mask) | (drain_word & drain_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      data_o <= `SBS_DATA_RST;
      parity_lines_o <= `SBS_PAR_RST;
    end
    else if (rd_now)
    begin
      data_o <= rd_word[`SBS_DATA_W-1:0];
      parity_lines_o <= rd_word[`SBS_WORD_W-1:`SBS_DATA_W];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      data_oe_n_o <= 1'b1;
      parity_oe_n_o <= 1'b1;
    end
    else
    begin
      data_oe_n_o <= output_enable_n_i || wr_detect || sleep_pin;
      parity_oe_n_o <= output_enable_n_i || wr_detect || sleep_pin;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      write_ready_o <= 1'b1;
      sleeping_o <= 1'b0;
    end
    else
    begin
      write_ready_o <= fifo_ready;
      sleeping_o <= sleep_pin;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  gw_all_lanes_a:
    assert property (wr_go && !global_write_n_i |-> wr_lanes == `SBS_LANE_ALL)
    else $error("global write did not select both lanes");
  select_combo_a:
    assert property (start |-> !chip_select_one_n_i && chip_select_two_i
                     && !chip_select_three_n_i)
    else $error("access started while deselected");
  processor_addr_strobe_n_gated_a:
    assert property (chip_select_one_n_i |-> !start)
    else $error("processor strobe honoured with select one high");
  oe_release_a:
    assert property (output_enable_n_i |=> data_oe_n_o && parity_oe_n_o)
    else $error("lines driven with output enable high");
  write_tristate_a:
    assert property (wr_detect |=> data_oe_n_o && parity_oe_n_o)
    else $error("lines driven in a write cycle");
  sleep_ignore_a:
    assert property (sleep_pin |-> !start && !wr_go && !rd_now ##1 state == SBS_SLEEP)
    else $error("input honoured during sleep");
  float_default_a:
    assert property (!mode_pin_driven_i && !sleep_pin_driven_i |-> interleave && !sleep_pin)
    else $error("undriven strap not at pull value");
  byte_lanes_a:
    assert property (wr_go && global_write_n_i |-> wr_lanes == ~byte_lane_select_n_i)
    else $error("byte lanes differ from lane selects");
  read_data_a:
    assert property (rd_now |=> {parity_lines_o, data_o} == $past(rd_word))
    else $error("read data not from captured address");
  burst_step_a:
    assert property (cont && !burst_step_n_i |=> seq == $past(seq) + 2'd1)
    else $error("burst counter did not step");

endmodule

`default_nettype wire

// [sbs_sram_tb.sv]
/*
  self-checking bench for sbs_sram: writes, byte writes, reads, bursts,
  chip select decoding and sleep, driven at the pins.
  assumes sbs_host_pad resolves the common data and parity lines.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sbs_cfg.svh"

module sbs_sram_tb;
  import sbs_pkg::*;

  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  sbs_addr_t addr = '0;
  logic ps_n = 1'b1;
  logic cas_n = 1'b1;
  logic step_n = 1'b1;
  logic cs1_n = 1'b1;
  logic cs2 = 1'b1;
  logic cs3_n = 1'b0;
  logic gw_n = 1'b1;
  logic bwe_n = 1'b1;
  sbs_lanes_t bws_n = 2'b11;
  logic oe_n = 1'b1;
  logic zz = 1'b0;
  logic zz_drv = 1'b1;
  logic mode = 1'b1;
  logic mode_drv = 1'b1;
  sbs_word_t host_w = '0;
  logic host_en = 1'b0;
  sbs_data_t dq_o;
  sbs_data_t dq_i;
  sbs_par_t dp_o;
  sbs_par_t dp_i;
  logic dq_oe_n;
  logic dp_oe_n;
  logic wr_rdy;
  logic slp;
  int miscompares = 0;
  int n_checks = 0;

  sbs_sram uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr),
    .processor_addr_strobe_n_i(ps_n), .controller_addr_strobe_n_i(cas_n),
    .burst_step_n_i(step_n), .chip_select_one_n_i(cs1_n), .chip_select_two_i(cs2),
    .chip_select_three_n_i(cs3_n), .global_write_n_i(gw_n), .byte_write_enable_n_i(bwe_n),
    .byte_lane_select_n_i(bws_n), .output_enable_n_i(oe_n), .sleep_request_i(zz),
    .sleep_pin_driven_i(zz_drv), .burst_mode_i(mode), .mode_pin_driven_i(mode_drv),
    .data_i(dq_i), .data_o(dq_o), .data_oe_n_o(dq_oe_n), .parity_lines_i(dp_i),
    .parity_lines_o(dp_o), .parity_oe_n_o(dp_oe_n), .write_ready_o(wr_rdy),
    .sleeping_o(slp));

  sbs_host_pad pad (.ref_clk_i(ref_clk_i), .host_word_i(host_w), .host_drive_i(host_en),
    .dev_data_i(dq_o), .dev_data_oe_n_i(dq_oe_n), .dev_par_i(dp_o),
    .dev_par_oe_n_i(dp_oe_n), .line_data_o(dq_i), .line_par_o(dp_i));

  ////////////////////////////////////////////////////////////////////////////////

  initial
  begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic test_done();
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cyc();
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic chk(input string nm, input sbs_word_t seen, input sbs_word_t exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic sbs_word_t wv(input int k);
    return {2'(k), 16'hC0D0 + 16'(k)};
  endfunction

  // deselect ends any burst, then idle edges let the write buffer drain
  task automatic quiet();
    ps_n = 1'b1;
    cas_n = 1'b0;
    cs1_n = 1'b1;
    host_en = 1'b0;
    gw_n = 1'b1;
    bwe_n = 1'b1;
    step_n = 1'b1;
    oe_n = 1'b1;
    cyc();
    cas_n = 1'b1;
    repeat (3) cyc();
  endtask

  task automatic wr(input sbs_addr_t a, input sbs_word_t w, input logic g_n,
    input logic b_n, input sbs_lanes_t l_n, input logic [2:0] sel);
    {cs1_n, cs2, cs3_n} = sel;
    addr = a;
    cas_n = 1'b0;
    gw_n = g_n;
    bwe_n = b_n;
    bws_n = l_n;
    host_w = w;
    host_en = 1'b1;
    cyc();
    chk("oe on write", sbs_word_t'({dp_oe_n, dq_oe_n}), 18'h0_0003);
    quiet();
  endtask

  task automatic rd(input sbs_addr_t a, input sbs_word_t exp);
    {cs1_n, cs2, cs3_n} = 3'b010;
    addr = a;
    ps_n = 1'b0;
    oe_n = 1'b0;
    cyc();
    ps_n = 1'b1;
    chk("read word", {dp_o, dq_o}, exp);
    chk("oe on read", sbs_word_t'({dp_oe_n, dq_oe_n}), 18'h0_0000);
  endtask

  initial
  begin
    #20000;
    miscompares++;
    test_done();
  end

  initial
  begin
    repeat (12) cyc();
    chk("reset outputs", sbs_word_t'({dp_oe_n, dq_oe_n, wr_rdy, slp}), 18'h0_000E);
    rst_i = 1'b0;
    cyc();
    wr(18'h0_0004, 18'h1_A5C3, 1'b0, 1'b0, 2'b11, 3'b010);
    rd(18'h0_0004, 18'h1_A5C3);
    quiet();
    for (int j = 0; j < 4; j++)
      wr(18'h0_0008 + 18'(j), wv(j), 1'b0, 1'b1, 2'b11, 3'b010);
    for (int m = 0; m < 3; m++)
    begin
      mode = (m == 0);
      mode_drv = (m != 2);
      rd(18'h0_0009, wv(1));
      for (int b = 1; b < 4; b++)
      begin
        step_n = 1'b0;
        cyc();
        chk("burst word", {dp_o, dq_o}, wv((m == 1) ? (1 + b) % 4 : 1 ^ b));
      end
      quiet();
    end
    wr(18'h0_0009, 18'h3_5A5A, 1'b1, 1'b0, 2'b10, 3'b010);
    wr(18'h0_000A, 18'h2_7E7E, 1'b1, 1'b0, 2'b01, 3'b010);
    wr(18'h0_000B, 18'h0_0000, 1'b1, 1'b1, 2'b00, 3'b010);
    rd(18'h0_0009, (wv(1) & `SBS_LANE1_MASK) | (18'h3_5A5A & `SBS_LANE0_MASK));
    quiet();
    rd(18'h0_000A, (wv(2) & `SBS_LANE0_MASK) | (18'h2_7E7E & `SBS_LANE1_MASK));
    quiet();
    rd(18'h0_000B, wv(3));
    quiet();
    oe_n = 1'b0;
    wr(18'h0_000D, 18'h3_0303, 1'b0, 1'b1, 2'b11, 3'b010);
    for (int s = 0; s < 8; s++)
      if (s != 2)
        wr(18'h0_000D, 18'h0_0F00 + 18'(s), 1'b0, 1'b1, 2'b11, 3'(s));
    rd(18'h0_000D, 18'h3_0303);
    quiet();
    {cs1_n, cs2, cs3_n} = 3'b110;
    addr = 18'h0_0004;
    ps_n = 1'b0;
    oe_n = 1'b0;
    cyc();
    ps_n = 1'b1;
    cyc();
    chk("gated strobe", {dp_o, dq_o}, 18'h3_0303);
    quiet();
    zz = 1'b1;
    wr(18'h0_000D, 18'h0_0001, 1'b0, 1'b1, 2'b11, 3'b010);
    chk("sleeping", sbs_word_t'(slp), 18'h0_0001);
    zz = 1'b0;
    cyc();
    rd(18'h0_000D, 18'h3_0303);
    quiet();
    zz_drv = 1'b0;
    zz = 1'b1;
    wr(18'h0_000D, 18'h0_0002, 1'b0, 1'b1, 2'b11, 3'b010);
    chk("floating sleep", sbs_word_t'(slp), 18'h0_0000);
    rd(18'h0_000D, 18'h0_0002);
    quiet();
    // a reset in mid-run clears the pins but keeps the array
    rst_i = 1'b1;
    cyc();
    chk("mid reset", sbs_word_t'({dp_oe_n, dq_oe_n, wr_rdy, slp}), 18'h0_000E);
    chk("mid reset data", {dp_o, dq_o}, 18'h0_0000);
    rst_i = 1'b0;
    cyc();
    rd(18'h0_000D, 18'h0_0002);
    quiet();
    // processor strobe: first edge reads, write lands on the next edge
    {cs1_n, cs2, cs3_n} = 3'b010;
    addr = 18'h0_0004;
    ps_n = 1'b0;
    gw_n = 1'b0;
    host_w = 18'h2_3C3C;
    host_en = 1'b1;
    cyc();
    chk("strobe ignores write", {dp_o, dq_o}, 18'h1_A5C3);
    ps_n = 1'b1;
    cyc();
    chk("oe on burst write", sbs_word_t'({dp_oe_n, dq_oe_n}), 18'h0_0003);
    quiet();
    rd(18'h0_0004, 18'h2_3C3C);
    quiet();
    test_done();
  end
endmodule

`default_nettype wire
